//--- logic/mlx_pkg.sv
`default_nettype none
package mlx_pkg;
  // Operation selector presented by the instruction decoder
  localparam logic [2:0] OP_NONE        = 3'h0;
  localparam logic [2:0] OP_LIT_TO_PCL  = 3'h1;
  localparam logic [2:0] OP_LIT_TO_ACC  = 3'h2;
  localparam logic [2:0] OP_ACC_TO_REG  = 3'h3;
  localparam logic [2:0] OP_ACC_IND_UPD = 3'h4;
  localparam logic [2:0] OP_ACC_IND_REL = 3'h5;
  // Pointer update codes
  localparam logic [1:0] UPD_PRE_INC    = 2'h0;
  localparam logic [1:0] UPD_PRE_DEC    = 2'h1;
  localparam logic [1:0] UPD_POST_INC   = 2'h2;
  localparam logic [1:0] UPD_POST_DEC   = 2'h3;
  // Widths
  localparam int PCL_W  = 7;
  localparam int ACC_W  = 8;
  localparam int FADR_W = 7;
  localparam int PTR_W  = 16;
  localparam int OFS_W  = 6;
  // Reset values and the pointer step
  localparam logic [PCL_W-1:0] PCL_RST = 7'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
endpackage
`default_nettype wire

//--- logic/mlx_exec.sv
`default_nettype none
// Contract
// - Literal to pc latch loads 7-bit literal, no status flag change.
// - Literal to accumulator loads 8-bit literal, no status flag change.
// - Store accumulator to 7-bit addressed file register in one cycle.
// - Indirect store writes accumulator at address held by selected pointer.
// - Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec, step one.
// - Pre modes write at updated pointer; post modes write original then update.
// - Relative form writes at pointer plus signed -32..31, pointer unchanged.
// - Pointer arithmetic wraps modulo 16 bits.
// - Indirect store and pointer updates never touch any status flag.
module mlx_exec (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Decoded instruction
  input  wire logic                        exec_i,
  input  wire logic [2:0]                  op_i,
  input  wire logic [7:0]                  literal_i,
  input  wire logic                        ptr_sel_i,
  input  wire logic [1:0]                  upd_code_i,
  // Architectural state
  output logic [mlx_pkg::PCL_W-1:0]        pc_latch_o,
  output logic [mlx_pkg::ACC_W-1:0]        acc_o,
  output logic [mlx_pkg::PTR_W-1:0]        ptr0_o,
  output logic [mlx_pkg::PTR_W-1:0]        ptr1_o,
  // Write port to file registers and data memory
  output logic                             freg_we_o,
  output logic [mlx_pkg::FADR_W-1:0]       freg_addr_o,
  output logic                             mem_we_o,
  output logic [mlx_pkg::PTR_W-1:0]        mem_addr_o,
  output logic [mlx_pkg::ACC_W-1:0]        wr_data_o,
  // Status flag write enable, never raised here
  output logic                             flag_we_o
);
  import mlx_pkg::*;

  logic [PCL_W-1:0]  pcl_reg;
  logic [ACC_W-1:0]  acc_reg;
  logic [PTR_W-1:0]  ptr_reg [2];
  logic              freg_we_reg;
  logic [FADR_W-1:0] freg_addr_reg;
  logic              mem_we_reg;
  logic [PTR_W-1:0]  mem_addr_reg;
  logic [ACC_W-1:0]  wr_data_reg;

  // Pointer chosen by the one-bit index
  function automatic logic [PTR_W-1:0] pick_ptr(input logic             sel,
                                                input logic [PTR_W-1:0] p0,
                                                input logic [PTR_W-1:0] p1);
    pick_ptr = sel ? p1 : p0;
  endfunction

  // Plain 16-bit step drops the carry on purpose, so wrap comes for free
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] ptr,
                                                input logic             down);
    ptr_step = down ? ptr - PTR_ONE : ptr + PTR_ONE;
  endfunction

  // Instruction decode
  wire               do_pcl = exec_i && (op_i == OP_LIT_TO_PCL);
  wire               do_acc = exec_i && (op_i == OP_LIT_TO_ACC);
  wire               do_reg = exec_i && (op_i == OP_ACC_TO_REG);
  wire               do_upd = exec_i && (op_i == OP_ACC_IND_UPD);
  wire               do_rel = exec_i && (op_i == OP_ACC_IND_REL);
  // Both indirect forms share one write strobe
  wire               do_ind = do_upd || do_rel;
  wire               do_store = do_reg || do_ind;

  // Pointer arithmetic
  wire [PTR_W-1:0]   ptr_cur = pick_ptr(ptr_sel_i, ptr_reg[0], ptr_reg[1]);
  wire [PTR_W-1:0]   ptr_inc = ptr_step(ptr_cur, 1'h0);
  wire [PTR_W-1:0]   ptr_dec = ptr_step(ptr_cur, 1'h1);
  wire [PTR_W-1:0]   ptr_new = upd_code_i[0] ? ptr_dec : ptr_inc;
  // Pre modes address the updated value, post modes the original
  wire [PTR_W-1:0]   upd_addr = upd_code_i[1] ? ptr_cur : ptr_new;
  // Offset sits in the low six literal bits; the upper two are ignored
  wire [PTR_W-1:0]   ofs_ext = {{(PTR_W-OFS_W){literal_i[OFS_W-1]}}, literal_i[OFS_W-1:0]};
  wire [PTR_W-1:0]   rel_addr = ptr_cur + ofs_ext;
  wire [PTR_W-1:0]   ind_addr = do_rel ? rel_addr : upd_addr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcl_reg    <= PCL_RST;
      acc_reg    <= ACC_RST;
      ptr_reg[0] <= PTR_RST;
      ptr_reg[1] <= PTR_RST;
    end else begin
      if (do_pcl) pcl_reg <= literal_i[PCL_W-1:0];
      if (do_acc) acc_reg <= literal_i;
      if (do_upd) ptr_reg[ptr_sel_i] <= ptr_new;
    end
  end

  // Write strobes registered; the indirect port itself stores nothing
  // Address and data hold until the next store, only the strobes pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freg_we_reg   <= 1'h0;
      freg_addr_reg <= '0;
      mem_we_reg    <= 1'h0;
      mem_addr_reg  <= PTR_RST;
      wr_data_reg   <= ACC_RST;
    end else begin
      freg_we_reg <= do_reg;
      mem_we_reg  <= do_ind;
      if (do_reg) freg_addr_reg <= literal_i[FADR_W-1:0];
      if (do_ind) mem_addr_reg <= ind_addr;
      if (do_store) wr_data_reg <= acc_reg;
    end
  end

  assign pc_latch_o  = pcl_reg;
  assign acc_o       = acc_reg;
  assign ptr0_o      = ptr_reg[0];
  assign ptr1_o      = ptr_reg[1];
  assign freg_we_o   = freg_we_reg;
  assign freg_addr_o = freg_addr_reg;
  assign mem_we_o    = mem_we_reg;
  assign mem_addr_o  = mem_addr_reg;
  assign wr_data_o   = wr_data_reg;
  assign flag_we_o   = 1'h0;

  // Pre forms store at the pointer after its step
  sequence s_upd_issue;
    do_upd && !upd_code_i[1];
  endsequence

  // Post forms store at the pointer before its step
  sequence s_post_issue;
    do_upd && upd_code_i[1];
  endsequence

  // Stepping up from the top value must come round to zero
  sequence s_inc_at_top;
    do_upd && !upd_code_i[0] && (ptr_cur == 16'hffff);
  endsequence

  // Stepping down from zero must come round to the top value
  sequence s_dec_at_bottom;
    do_upd && upd_code_i[0] && (ptr_cur == 16'h0000);
  endsequence

  AST_PCL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    do_pcl |=> pc_latch_o == $past(literal_i[PCL_W-1:0]))
    else $error("pc latch not loaded");

  AST_PCL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !do_pcl |=> $stable(pc_latch_o))
    else $error("pc latch changed without load");

  AST_ACC_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    do_acc |=> acc_o == $past(literal_i))
    else $error("accumulator not loaded");

  AST_ACC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !do_acc |=> $stable(acc_o))
    else $error("accumulator changed without load");

  AST_REG_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
    do_reg |=> freg_we_o && freg_addr_o == $past(literal_i[FADR_W-1:0])
      && wr_data_o == $past(acc_o))
    else $error("file register store wrong");

  AST_REG_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    !do_reg |=> !freg_we_o)
    else $error("file register strobe without store");

  AST_IND_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
    do_ind |=> mem_we_o && wr_data_o == $past(acc_o))
    else $error("indirect store data wrong");

  AST_IND_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    !do_ind |=> !mem_we_o)
    else $error("indirect strobe without store");

  // One store per instruction, so the two ports never write together
  AST_ONE_PORT: assert property (@(posedge clk_i) disable iff (rst_i)
    !(freg_we_o && mem_we_o))
    else $error("both write ports raised");

  AST_PRE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_upd_issue |=> mem_addr_o == pick_ptr($past(ptr_sel_i), ptr0_o, ptr1_o))
    else $error("pre mode address not updated pointer");

  AST_POST_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_post_issue |=> mem_addr_o == $past(ptr_cur))
    else $error("post mode address not original pointer");

  // The selector may change on the next instruction, so its past value picks
  AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    do_upd |=> pick_ptr($past(ptr_sel_i), ptr0_o, ptr1_o) - $past(ptr_cur)
      == ($past(upd_code_i[0]) ? 16'hffff : 16'h0001))
    else $error("pointer step wrong");

  AST_OTHER_PTR: assert property (@(posedge clk_i) disable iff (rst_i)
    do_upd |=> ($past(ptr_sel_i) ? $stable(ptr0_o) : $stable(ptr1_o)))
    else $error("unselected pointer moved");

  AST_PTR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !do_upd |=> $stable(ptr0_o) && $stable(ptr1_o))
    else $error("pointer moved without update form");

  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_inc_at_top |=> pick_ptr($past(ptr_sel_i), ptr0_o, ptr1_o) == 16'h0000)
    else $error("pointer wrap up wrong");

  AST_WRAP_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
    s_dec_at_bottom |=> pick_ptr($past(ptr_sel_i), ptr0_o, ptr1_o) == 16'hffff)
    else $error("pointer wrap down wrong");

  AST_REL: assert property (@(posedge clk_i) disable iff (rst_i)
    do_rel |=> $stable(ptr0_o) && $stable(ptr1_o)
      && mem_addr_o == $past(ptr_cur) + $past(ofs_ext))
    else $error("relative store wrong");

  // Flags belong to a neighbouring block; this one must never ask to write them
  AST_NOFLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    do_ind |=> !flag_we_o [*2])
    else $error("flag write raised");
endmodule
`default_nettype wire

//--- dv/mlx_exec_test.sv
`default_nettype none
module mlx_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mlx_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, exec_i = 1'h0, ptr_sel_i = 1'h0;
  logic [2:0] op_i = 3'h0;
  logic [7:0] literal_i = 8'h00, acc = 8'h00, d;
  logic [1:0] upd_code_i = 2'h0;
  logic [6:0] pc_latch_o, freg_addr_o, pcl = 7'h00;
  logic [7:0] acc_o, wr_data_o;
  logic [15:0] ptr0_o, ptr1_o, mem_addr_o, p0 = 16'h0000, p1 = 16'h0000, a, p;
  logic freg_we_o, mem_we_o, flag_we_o, fw, mw;
  logic [73:0] q[$], got, ex;
  int n_mismatch = 0, num_checks = 0;
  mlx_exec dut (.clk_i(clk_i), .rst_i(rst_i), .exec_i(exec_i), .op_i(op_i),
    .literal_i(literal_i), .ptr_sel_i(ptr_sel_i), .upd_code_i(upd_code_i),
    .pc_latch_o(pc_latch_o), .acc_o(acc_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
    .freg_we_o(freg_we_o), .freg_addr_o(freg_addr_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .wr_data_o(wr_data_o), .flag_we_o(flag_we_o));
  initial forever #4 clk_i = ~clk_i;
  // Model follows each issued instruction; addr and data only matter with a strobe
  task automatic drv(input logic e, input logic [2:0] o, input logic [7:0] l,
                     input logic s, input logic [1:0] c);
    @(negedge clk_i);
    {exec_i, op_i, literal_i, ptr_sel_i, upd_code_i} = {e, o, l, s, c};
    {fw, mw, a, d} = '0;
    p = s ? p1 : p0;
    if (e) begin
      case (o)
        OP_LIT_TO_PCL: pcl = l[6:0];
        OP_LIT_TO_ACC: acc = l;
        OP_ACC_TO_REG: {fw, a, d} = {1'b1, 9'h0, l[6:0], acc};
        OP_ACC_IND_UPD: begin
          {mw, a, d} = {1'b1, p, acc};
          p = c[0] ? p - PTR_ONE : p + PTR_ONE;
          if (!c[1]) a = p;
        end
        OP_ACC_IND_REL: {mw, a, d} = {1'b1, p + {{10{l[5]}}, l[5:0]}, acc};
        default: ;
      endcase
    end
    // Idle calls are noted too, so a strobe that stays up is caught
    if (s) p1 = p;
    else p0 = p;
    q.push_back({fw, mw, a, d, p0, p1, acc, pcl, 1'h0});
  endtask
  always @(posedge clk_i) if (!rst_i && q.size() != 0) begin
    #1;
    got = {freg_we_o, mem_we_o, freg_we_o ? {9'h0, freg_addr_o} : mem_we_o ? mem_addr_o : 16'h0,
           (freg_we_o | mem_we_o) ? wr_data_o : 8'h0, ptr0_o, ptr1_o, acc_o, pc_latch_o, flag_we_o};
    ex = q.size() ? q.pop_front() : '1;
    num_checks++;
    if (got !== ex) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
      n_mismatch++;
    end
  end
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Random mix keeps ops back to back, including refused codes 0, 6 and 7
  task automatic burst(input int n);
    repeat (n) drv($urandom_range(0, 3) != 0, 3'($urandom_range(0, 7)), 8'($urandom),
                   1'($urandom), 2'($urandom));
  endtask
  initial begin
    void'($urandom(24));
    repeat (2) @(negedge clk_i);
    rst_i = 1'h0;
    drv(1'h1, OP_LIT_TO_ACC, 8'h5a, 1'h0, 2'h0);
    drv(1'h1, OP_ACC_IND_UPD, 8'h00, 1'h0, UPD_PRE_DEC);
    drv(1'h1, OP_ACC_IND_UPD, 8'h00, 1'h0, UPD_PRE_INC);
    drv(1'h1, OP_ACC_IND_UPD, 8'h00, 1'h0, UPD_POST_DEC);
    drv(1'h1, OP_ACC_IND_UPD, 8'h00, 1'h0, UPD_POST_INC);
    drv(1'h1, OP_ACC_IND_REL, 8'h20, 1'h1, 2'h0);
    drv(1'h1, OP_ACC_IND_REL, 8'hdf, 1'h1, 2'h0);
    drv(1'h1, OP_LIT_TO_PCL, 8'hff, 1'h0, 2'h0);
    drv(1'h1, OP_ACC_TO_REG, 8'hff, 1'h0, 2'h0);
    burst(600);
    @(negedge clk_i);
    {exec_i, p0, p1, acc, pcl} = '0;
    rst_i = 1'h1;
    @(negedge clk_i);
    rst_i = 1'h0;
    burst(200);
    drv(1'h0, 3'h0, 8'h00, 1'h0, 2'h0);
    repeat (2) @(negedge clk_i);
    final_report();
  end
  initial begin
    #(8 * 2000);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
